// ==== logic/fsp_defs.svh ====
// Offsets, field positions, reset values and timing counts of the flash self-program control
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
`define FSP_CTRL_OFF      8'h00
`define FSP_BOOT_CFG_OFF  8'h04
`define FSP_BOOT_ADDR_OFF 8'h08
`define FSP_BIT_SE        0
`define FSP_BIT_ERS       1
`define FSP_BIT_WRT       2
`define FSP_BIT_LCK       3
`define FSP_BIT_RRE       4
`define FSP_BIT_SIG       5
`define FSP_BIT_RWWB      6
`define FSP_CTRL_RST      6'h00
`define FSP_BOOT_CFG_RST  2'h0
`define FSP_STORE_WIN     3'h4
`define FSP_LOAD_WIN      3'h3
`define FSP_RWW_PAGES     7'h60
`define FSP_NO_READ_WHILE_WRITE_AREA_START    12'hc00
`define FSP_BUF_ERASED    16'hffff
`define FSP_CLK_MHZ       40
`define FSP_PROG_MIN_US   3700
`define FSP_PROG_MAX_US   4500
`define FSP_PROG_CYCLES   (`FSP_PROG_MIN_US * `FSP_CLK_MHZ)
`define FSP_SIG1_ADDR     3'h0
`define FSP_CAL_ADDR      3'h1
`define FSP_SIG2_ADDR     3'h2
`define FSP_SIG3_ADDR     3'h4
`define FSP_RESP_OKAY     2'h0
`define FSP_RESP_SLVERR   2'h2
`endif

// ==== logic/fsp_pkg.sv ====
// Types of the flash self-program control
package fsp_pkg;
   typedef enum logic [1:0] {FSP_IDLE, FSP_ARMED, FSP_PROG} fsp_state_t;
endpackage : fsp_pkg

// ==== logic/fsp_prog_timer.sv ====
// Erase, write and lock duration counter
`timescale 1ns/1ps
`default_nettype none
module fsp_prog_timer #(
   parameter int unsigned CYCLES = 148000
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Control
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   logic [17:0] cnt_q;
   logic        busy_q;

   assign busy = busy_q;
   assign done = busy_q && (cnt_q == 18'h00001);

   // A running operation survives reset
   always_ff @(posedge clk) begin
      if (!reset_n && !busy_q) begin
         cnt_q  <= 18'h00000;
         busy_q <= 1'b0;
      end else if (start && !busy_q) begin
         cnt_q  <= 18'(CYCLES);
         busy_q <= 1'b1;
      end else if (busy_q) begin
         cnt_q  <= cnt_q - 18'h00001;
         busy_q <= (cnt_q != 18'h00001);
      end
   end
endmodule : fsp_prog_timer
`default_nettype wire

// ==== logic/fsp_ctrl.sv ====
// Flash self-program control with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`include "fsp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module fsp_ctrl import fsp_pkg::*; #(
   parameter int unsigned PROG_CYCLES = `FSP_PROG_CYCLES,
   parameter logic [7:0]  SIG_BYTE1   = 8'h11, // Arbitrary value
   parameter logic [7:0]  SIG_BYTE2   = 8'h22, // Arbitrary value
   parameter logic [7:0]  SIG_BYTE3   = 8'h33, // Arbitrary value
   parameter logic [7:0]  CAL_BYTE    = 8'h80
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // CPU store and load instructions
   input  wire logic        store_exec,
   input  wire logic        load_exec,
   input  wire logic [15:0] addr_ptr,
   input  wire logic [15:0] store_data,
   output logic [7:0]       load_data,
   output logic             load_valid,
   input  wire logic        eeprom_write_busy,
   // Instruction fetch guard
   input  wire logic [11:0] fetch_addr,
   output logic             fetch_stall,
   output logic             cpu_halt,
   output logic [11:0]      boot_reset_addr,
   // Flash array
   output logic [11:0]      flash_raddr,
   input  wire logic [15:0] flash_rdata,
   output logic             flash_erase,
   output logic             flash_write,
   output logic             flash_lock,
   output logic [6:0]       flash_page,
   output logic [7:0]       flash_lock_data,
   input  wire logic [4:0]  flash_buf_idx,
   output logic [15:0]      flash_buf_data
);
   fsp_state_t  state_q;
   logic [5:0]  ctrl_q;
   logic        rww_busy_q;
   logic [2:0]  win_q;
   logic [1:0]  boot_sz_q;
   logic [6:0]  page_q;
   logic [15:0] buf_q [32];
   logic [7:0]  load_data_q;
   logic        load_valid_q;
   logic [2:0]  fop_q;
   logic [7:0]  lock_q;
   logic [15:0] buf_rd_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;

   // Bus decode
   wire wr_fire  = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
   wire wr_ctrl  = wr_fire && (s_axi_awaddr == `FSP_CTRL_OFF);
   wire wr_cfg   = wr_fire && (s_axi_awaddr == `FSP_BOOT_CFG_OFF);
   wire wr_ro    = wr_fire && (s_axi_awaddr == `FSP_BOOT_ADDR_OFF);
   wire wr_busy  = eeprom_write_busy || (state_q != FSP_IDLE);
   wire ctrl_ok  = wr_ctrl && s_axi_wstrb[0] && !wr_busy
                   && s_axi_wdata[`FSP_BIT_SE];
   wire rd_fire  = s_axi_arvalid && !rvalid_q;
   wire rd_ctrl  = s_axi_araddr == `FSP_CTRL_OFF;
   wire rd_cfg   = s_axi_araddr == `FSP_BOOT_CFG_OFF;
   wire rd_badr  = s_axi_araddr == `FSP_BOOT_ADDR_OFF;
   wire [7:0] status_byte = {1'b0, rww_busy_q, ctrl_q};

   assign s_axi_awready = wr_fire;
   assign s_axi_wready  = wr_fire;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = rd_fire;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // Pointer mapping, upper bits dropped
   wire [6:0] z_page = addr_ptr[12:6];
   wire [4:0] z_word = addr_ptr[5:1];
   wire       z_byte = addr_ptr[0];
   assign flash_raddr = addr_ptr[12:1];

   // Armed command decode
   wire armed    = state_q == FSP_ARMED;
   wire sig_mode = armed && ctrl_q[`FSP_BIT_SIG] && ctrl_q[`FSP_BIT_SE];
   wire sig_hit  = sig_mode && load_exec;
   wire st_hit   = armed && !ctrl_q[`FSP_BIT_SIG] && store_exec;
   wire is_ers   = ctrl_q[`FSP_BIT_ERS];
   wire is_wrt   = ctrl_q[`FSP_BIT_WRT];
   wire is_lck   = ctrl_q[`FSP_BIT_LCK];
   wire is_rre   = ctrl_q[`FSP_BIT_RRE];
   wire is_fill  = !(is_ers || is_wrt || is_lck || is_rre);
   wire long_op  = st_hit && (is_ers || is_wrt || is_lck);
   wire win_end  = armed && (win_q == 3'h1) && !sig_hit && !st_hit;
   wire in_rww   = z_page < `FSP_RWW_PAGES;
   wire tmr_busy;
   wire tmr_done;

   fsp_prog_timer #(
      .CYCLES (PROG_CYCLES)
   ) u_timer (
      .clk     (clk),
      .reset_n (reset_n),
      .start   (long_op),
      .busy    (tmr_busy),
      .done    (tmr_done)
   );

   // Signature row byte by pointer
   wire [7:0] sig_byte =
      (addr_ptr[2:0] == `FSP_SIG1_ADDR) ? SIG_BYTE1 :
      (addr_ptr[2:0] == `FSP_SIG2_ADDR) ? SIG_BYTE2 :
      (addr_ptr[2:0] == `FSP_SIG3_ADDR) ? SIG_BYTE3 :
      (addr_ptr[2:0] == `FSP_CAL_ADDR)  ? CAL_BYTE  : 8'h00;
   wire [7:0] flash_byte = z_byte ? flash_rdata[15:8] : flash_rdata[7:0];

   // Boot section start
   assign boot_reset_addr = (boot_sz_q == 2'h3) ? 12'hf80 :
                            (boot_sz_q == 2'h2) ? 12'hf00 :
                            (boot_sz_q == 2'h1) ? 12'he00 : 12'hc00;

   // Fetch blocking
   assign fetch_stall = rww_busy_q && (fetch_addr < `FSP_NO_READ_WHILE_WRITE_AREA_START);
   assign cpu_halt = (state_q == FSP_PROG) && !ctrl_q[`FSP_BIT_LCK]
                     && (page_q >= `FSP_RWW_PAGES);
   assign load_data  = load_data_q;
   assign load_valid = load_valid_q;
   assign flash_erase = fop_q[0];
   assign flash_write = fop_q[1];
   assign flash_lock  = fop_q[2];
   assign flash_page  = page_q;
   assign flash_lock_data = lock_q;
   assign flash_buf_data  = buf_rd_q;

   // Sequencer, kept through reset while programming
   always_ff @(posedge clk) begin
      if (!reset_n && state_q != FSP_PROG) begin
         state_q <= FSP_IDLE;
         ctrl_q  <= `FSP_CTRL_RST;
         win_q   <= 3'h0;
      end else begin
         unique case (state_q)
            FSP_IDLE: begin
               if (ctrl_ok) begin
                  ctrl_q  <= s_axi_wdata[5:0];
                  state_q <= FSP_ARMED;
                  win_q   <= s_axi_wdata[`FSP_BIT_SIG] ? `FSP_LOAD_WIN
                                                       : `FSP_STORE_WIN;
               end
            end
            FSP_ARMED: begin
               win_q <= win_q - 3'h1;
               if (long_op) begin
                  state_q <= FSP_PROG;
               end else if (sig_hit || st_hit || win_end) begin
                  state_q <= FSP_IDLE;
                  ctrl_q  <= `FSP_CTRL_RST;
               end
            end
            FSP_PROG: begin
               if (tmr_done) begin
                  state_q <= FSP_IDLE;
                  ctrl_q  <= `FSP_CTRL_RST;
               end
            end
         endcase
      end
   end

   // Read-while-write busy flag
   always_ff @(posedge clk) begin
      if (!reset_n && state_q != FSP_PROG) begin
         rww_busy_q <= 1'b0;
      end else if (long_op && (is_ers || is_wrt) && in_rww) begin
         rww_busy_q <= 1'b1;
      end else if (st_hit && is_rre && !tmr_busy) begin
         rww_busy_q <= 1'b0;
      end
   end

   // Page latch and flash strobes
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fop_q <= 3'h0;
      end else begin
         fop_q <= {long_op && is_lck, long_op && is_wrt, long_op && is_ers};
      end
      if (long_op) begin
         page_q <= z_page;
         lock_q <= store_data[7:0];
      end
      buf_rd_q <= buf_q[flash_buf_idx];
   end

   // Temporary page buffer
   always_ff @(posedge clk) begin
      for (int i = 0; i < 32; i++) begin
         if (!reset_n || (st_hit && is_rre)
             || (tmr_done && ctrl_q[`FSP_BIT_WRT])) begin
            buf_q[i] <= `FSP_BUF_ERASED;
         end else if (st_hit && is_fill && z_word == 5'(i)) begin
            buf_q[i] <= store_data;
         end
      end
   end

   // Load result
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         load_data_q  <= 8'h00;
         load_valid_q <= 1'b0;
      end else begin
         load_valid_q <= load_exec;
         if (load_exec) begin
            load_data_q <= sig_mode ? sig_byte : flash_byte;
         end
      end
   end

   // Boot size configuration
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         boot_sz_q <= `FSP_BOOT_CFG_RST;
      end else if (wr_cfg && s_axi_wstrb[0]) begin
         boot_sz_q <= s_axi_wdata[1:0];
      end
   end

   // Bus responses
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `FSP_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= ((wr_ctrl && wr_busy) || !(wr_ctrl || wr_cfg || wr_ro))
                     ? `FSP_RESP_SLVERR : `FSP_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= `FSP_RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_ctrl ? {24'h000000, status_byte} :
                     rd_cfg  ? {30'h00000000, boot_sz_q} :
                     rd_badr ? {20'h00000, boot_reset_addr} : 32'h00000000;
         rresp_q  <= (rd_ctrl || rd_cfg || rd_badr) ? `FSP_RESP_OKAY
                                                    : `FSP_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Checks
   sequence s_sig_arm;
      ctrl_ok && s_axi_wdata[`FSP_BIT_SIG];
   endsequence
   sequence s_sig_drop;
      !ctrl_q[`FSP_BIT_SE] && state_q == FSP_IDLE;
   endsequence

   a_sig_timeout: assert property (@(posedge clk) disable iff (!reset_n)
      s_sig_arm ##1 !load_exec [*3] |=> s_sig_drop)
      else $error("signature bits not cleared after window");
   a_sig_read: assert property (@(posedge clk) disable iff (!reset_n)
      sig_hit |=> load_valid && load_data == $past(sig_byte) ##0 s_sig_drop)
      else $error("signature byte not returned");
   a_cal_byte: assert property (@(posedge clk) disable iff (!reset_n)
      sig_hit && addr_ptr[2:0] == 3'h1 |=> load_data == CAL_BYTE)
      else $error("calibration byte wrong");
   a_normal_load: assert property (@(posedge clk) disable iff (!reset_n)
      load_exec && !sig_mode |=> load_data == $past(flash_byte))
      else $error("normal load redirected");
   a_store_window: assert property (@(posedge clk) disable iff (!reset_n)
      ctrl_ok && !s_axi_wdata[`FSP_BIT_SIG] ##1 !store_exec [*4]
      |=> state_q == FSP_IDLE && ctrl_q == 6'h00)
      else $error("store command outlived four cycles");
   a_prog_hold: assert property (@(posedge clk) disable iff (!reset_n)
      long_op |=> ctrl_q[`FSP_BIT_SE] [*8])
      else $error("store enable dropped early");
   a_rww_busy: assert property (@(posedge clk) disable iff (!reset_n)
      tmr_busy && (page_q < `FSP_RWW_PAGES) && !ctrl_q[`FSP_BIT_LCK]
      && state_q == FSP_PROG |-> rww_busy_q)
      else $error("busy flag clear during programming");
   a_fetch_block: assert property (@(posedge clk) disable iff (!reset_n)
      rww_busy_q && fetch_addr < 12'hc00 |-> fetch_stall)
      else $error("read-while-write area fetched while busy");
   a_boot_addr: assert property (@(posedge clk) disable iff (!reset_n)
      boot_sz_q == 2'h0 |-> boot_reset_addr == 12'hc00)
      else $error("boot address wrong");
endmodule : fsp_ctrl
`default_nettype wire

// ==== tb/fsp_flash_model.sv ====
// Flash array stand-in answering reads in the same cycle
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model (
   // Array read port
   input  wire logic [11:0] raddr,
   output logic      [15:0] rdata
);
   assign rdata = {4'ha, raddr};
endmodule : fsp_flash_model
`default_nettype wire

// ==== tb/flash_self_program_control_tb_top.sv ====
// Self-checking bench of the flash self-program control
`include "fsp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control_tb_top;
   localparam int PC = 20;
   localparam logic [1:0] OK = `FSP_RESP_OKAY;
   localparam logic [1:0] ER = `FSP_RESP_SLVERR;
   logic        clk = 0, reset_n = 0, push = 0;
   logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rd_v, exp_q[$];
   logic        st = 0, ld = 0, eeb = 0;
   logic [15:0] ptr = 0, sdat = 0, frd, p, w, d;
   logic [11:0] faddr = 0, fra, bra;
   logic [4:0]  bidx = 0;
   logic [1:0]  resp;
   wire         awr, wr_r, bv, arr, rv, lv, stall, halt, fe, fw, fl;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  ldat, lkd;
   wire  [6:0]  pg;
   wire  [15:0] bdat;
   logic [7:0]  sv[4] = '{8'h5a, 8'h80, 8'h96, 8'h3c};
   logic [2:0]  sa[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
   int num_errors = 0, n_tests = 0, seed = 32'hab5c2080, cyc = 0, i, k;

   fsp_ctrl #(.PROG_CYCLES(PC), .SIG_BYTE1(8'h5a), .SIG_BYTE2(8'h96),
      .SIG_BYTE3(8'h3c), .CAL_BYTE(8'h80)) fsp_ctrl_inst (
      .clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rready), .store_exec(st), .load_exec(ld),
      .addr_ptr(ptr), .store_data(sdat), .load_data(ldat),
      .load_valid(lv), .eeprom_write_busy(eeb), .fetch_addr(faddr),
      .fetch_stall(stall), .cpu_halt(halt), .boot_reset_addr(bra),
      .flash_raddr(fra), .flash_rdata(frd), .flash_erase(fe),
      .flash_write(fw), .flash_lock(fl), .flash_page(pg),
      .flash_lock_data(lkd), .flash_buf_idx(bidx), .flash_buf_data(bdat));
   fsp_flash_model fsp_flash_model_inst (.raddr(fra), .rdata(frd));

   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= ((fe | fw | fl) === 1'b1) ? 0 : cyc + 1;
   end

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task automatic tmo;
      $display("CHECK FAILED wait expected 1 seen 0");
      num_errors++;
      stop_test();
   endtask : tmo
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
         num_errors++;
      end
   endtask : chk
   // Results noted by the drivers are taken off the queue as they appear
   always @(negedge clk) begin
      if (lv === 1'b1 || (rv === 1'b1 && rready === 1'b1 && push)) begin
         if (exp_q.size() == 0) chk("queue", 1, 0);
         else chk("result", exp_q.pop_front(), lv ? ldat : rdata);
      end
   end

   task automatic wr(logic [7:0] a, logic [31:0] dd, logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= dd;
      awv <= 1;
      wv <= 1;
      bready <= 1;
      @(negedge clk);
      for (i = 0; i < 50 && awr !== 1'b1; i++) @(negedge clk);
      if (awr !== 1'b1) tmo();
      @(posedge clk);
      awv <= 0;
      wv <= 0;
      @(negedge clk);
      for (i = 0; i < 50 && bv !== 1'b1; i++) @(negedge clk);
      if (bv !== 1'b1) tmo();
      resp = bresp;
      @(posedge clk);
      bready <= 0;
      chk("bresp", er, resp);
   endtask : wr
   task automatic rd(logic [7:0] a, logic [31:0] e, logic pu);
      @(posedge clk);
      araddr <= a;
      arv <= 1;
      rready <= 1;
      push <= pu;
      if (pu) exp_q.push_back(e);
      @(negedge clk);
      for (i = 0; i < 50 && arr !== 1'b1; i++) @(negedge clk);
      if (arr !== 1'b1) tmo();
      @(posedge clk);
      arv <= 0;
      @(negedge clk);
      for (i = 0; i < 50 && rv !== 1'b1; i++) @(negedge clk);
      if (rv !== 1'b1) tmo();
      rd_v = rdata;
      resp = rresp;
      @(posedge clk);
      rready <= 0;
      chk("rresp", (a > 8'h08) ? ER : OK, resp);
   endtask : rd
   // One store or load instruction, a single cycle long
   task automatic op(logic s, logic [15:0] pp, logic [15:0] dd);
      ptr <= pp;
      sdat <= dd;
      st <= s;
      ld <= !s;
      if (!s) exp_q.push_back(dd);
      @(posedge clk);
      st <= 0;
      ld <= 0;
   endtask : op
   task automatic poll;
      int n;
      for (n = 0; n < 30; n++) begin
         rd(8'h00, 0, 0);
         if (rd_v[0] === 1'b0) break;
      end
      if (n == 30) tmo();
      chk("prog time", 1, cyc >= PC && cyc <= PC + 10);
   endtask : poll
   task automatic strobe(logic [31:0] cmd, logic [15:0] pp);
      wr(8'h00, cmd, OK);
      op(1, pp, d);
      for (i = 0; i < 4 && (fe | fw | fl) !== 1'b1; i++) @(negedge clk);
      chk("strobe", 1, fe | fw | fl);
   endtask : strobe

   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1;
      rd(8'h00, 0, 1);
      rd(8'h0c, 0, 1);
      for (k = 0; k < 4; k++) begin
         wr(8'h04, k, OK);
         rd(8'h08, 32'h1000 - (32'h80 << (3 - k)), 1);
      end
      $display("test boot size done");
      for (k = 0; k < 4; k++) begin
         wr(8'h00, 32'h21, OK);
         op(0, (16'($random(seed)) & 16'he000) | sa[k], sv[k]);
         rd(8'h00, 0, 1);
      end
      wr(8'h00, 32'h21, OK);
      repeat (4) @(posedge clk);
      rd(8'h00, 0, 1);
      for (k = 0; k < 4; k++) begin
         @(posedge clk);
         p = k ? 16'($random(seed)) : 16'h0001;
         w = {4'ha, p[12:1]};
         op(0, p, p[0] ? w[15:8] : w[7:0]);
      end
      $display("test signature done");
      wr(8'h00, 32'h01, OK);
      repeat (5) @(posedge clk);
      op(1, 16'h0006, 16'h1234);
      bidx <= 5'd3;
      repeat (3) @(negedge clk);
      chk("late buf", 16'hffff, bdat);
      w = 16'($random(seed));
      d = 16'($random(seed));
      wr(8'h00, 32'h01, OK);
      op(1, {w[15:13], 7'd9, w[4:0], 1'b0}, d);
      bidx <= w[4:0];
      repeat (3) @(negedge clk);
      chk("buf word", d, bdat);
      $display("test buffer done");
      faddr <= 12'h100;
      strobe(32'h03, 16'he140);
      chk("page", 5, pg);
      chk("stall", 1, stall);
      chk("halt", 0, halt);
      poll();
      rd(8'h00, 0, 0);
      chk("busy", 1, rd_v[6]);
      chk("stall", 1, stall);
      faddr <= 12'hc00;
      @(negedge clk);
      chk("no_read_while_write_area", 0, stall);
      faddr <= 12'hbff;
      eeb <= 1;
      wr(8'h00, 32'h11, ER);
      eeb <= 0;
      wr(8'h00, 32'h11, OK);
      op(1, 16'h0000, 16'h0000);
      rd(8'h00, 0, 1);
      chk("stall", 0, stall);
      $display("test erase done");
      strobe(32'h05, 16'h1900);
      chk("halt", 1, halt);
      reset_n <= 0;
      repeat (2) @(posedge clk);
      reset_n <= 1;
      @(negedge clk);
      chk("halt", 1, halt);
      poll();
      chk("halt", 0, halt);
      strobe(32'h09, 16'h0000);
      chk("lock", d[7:0], lkd);
      poll();
      $display("test program done");
      stop_test();
   end
endmodule : flash_self_program_control_tb_top
`default_nettype wire
